/* File: verilog/sar_pkg.sv */
`default_nettype none
package sar_pkg;
    // Timing
    localparam int CLK_NS         = 50;
    localparam int ACQ_NS         = 400;
    localparam int CONV_NS        = 1600;
    localparam int ACQ_CYC        = (ACQ_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_CYC       = (CONV_NS / CLK_NS < 1) ? 1 : CONV_NS / CLK_NS;
    localparam int SCLK_HALF_CYC  = 2;
    localparam int LATE_PULSE_CYC = 8;
    localparam int RESULT_BITS    = 16;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    // Control word, field positions from bit 8 downward
    typedef struct packed {
        logic soft_reset;
        logic buffer_off;
        logic ref_off;
        logic power_down;
        logic code_format_select;
        logic shift_clock_invert;
        logic frame_marker_invert;
        logic external_clock_select;
        logic serial_select;
    } sar_ctrl_s;
    localparam logic [8:0] CTRL_RESET = 9'h000;
    // Status word
    typedef struct packed {
        logic shifting;
        logic powered_down;
        logic busy;
    } sar_status_s;
    // Conversion states
    typedef enum {ST_ACQ, ST_WAIT, ST_CONV, ST_PD} sar_conv_e;
endpackage
`default_nettype wire

/* File: verilog/sar_readout.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_readout (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        convert_strobe_n,
    input  wire logic        select_n,
    input  wire logic        read_strobe_n,
    input  wire logic        shift_clock_in,
    input  wire logic        readmode_or_chain_in,
    input  wire logic [15:0] sample_data,
    output logic      [15:0] data_out,
    output logic      [15:0] data_oe,
    output logic             shift_clock_out,
    output logic             shift_clock_oe,
    output logic             serial_result_out,
    output logic             frame_marker,
    output logic             late_read_flag,
    output logic             busy,
    output logic             ref_enable,
    output logic             buffer_enable,
    output logic             power_reduced
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    sar_pkg::sar_ctrl_s   ctrl;          // Control register
    sar_pkg::sar_status_s status;        // Status view
    sar_pkg::sar_conv_e   state;         // Conversion state
    logic [7:0]           cnt;           // Phase counter
    logic [15:0]          result;        // Latched result
    logic [15:0]          shreg;         // Output shift register
    logic                 shifting;      // Serial read running
    logic                 read_done;     // Read finished, await release
    logic [4:0]           bit_cnt;       // Shift clock periods seen
    logic [7:0]           div;           // Internal clock divider
    logic [7:0]           late_cnt;      // Late flag stretch
    logic [4:0]           s1;            // Synchroniser stage 1
    logic [4:0]           s2;            // Synchroniser stage 2
    logic [4:0]           s3;            // Synchroniser stage 3
    logic [4:0]           filt;          // Agreed input levels
    logic [4:0]           filt_d;        // Previous agreed levels
    logic                 cnv_f;         // Convert strobe level
    logic                 sel_f;         // Select level
    logic                 rd_f;          // Read strobe level
    logic                 sclk_f;        // External clock level
    logic                 chain_f;       // Chain or read mode level
    logic                 read_act;      // Select and read both low
    logic                 conv_done;     // Conversion ends this cycle
    logic                 late_evt;      // Late external read
    logic                 ext_edge;      // External update edge
    logic                 half_tick;     // Internal half period
    logic                 start;         // Serial read starts
    logic                 setup;         // APB setup phase
    logic                 wr_ctrl;       // Control write
    logic [15:0]          next_data;     // Next bus data
    logic [15:0]          next_oe;       // Next bus enables

    assign cnv_f   = filt[0];
    assign sel_f   = filt[1];
    assign rd_f    = filt[2];
    assign sclk_f  = filt[3];
    assign chain_f = filt[4];
    assign read_act = !sel_f && !rd_f;
    assign status   = '{shifting: shifting, powered_down: state == sar_pkg::ST_PD, busy: busy};

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, level accepted when stages two and three agree
    genvar gi;
    logic [4:0] pins;
    assign pins = {readmode_or_chain_in, shift_clock_in, read_strobe_n, select_n, convert_strobe_n};
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            // Three stage sampler per pin; strobe and select pins reset high, shift clock and chain low
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1[gi]     <= (gi < 3) ? 1'b1 : 1'b0;
                    s2[gi]     <= (gi < 3) ? 1'b1 : 1'b0;
                    s3[gi]     <= (gi < 3) ? 1'b1 : 1'b0;
                    filt[gi]   <= (gi < 3) ? 1'b1 : 1'b0;
                    filt_d[gi] <= (gi < 3) ? 1'b1 : 1'b0;
                end else begin
                    s1[gi] <= pins[gi];
                    s2[gi] <= s1[gi];
                    s3[gi] <= s2[gi];
                    if (s2[gi] == s3[gi]) begin
                        filt[gi] <= s3[gi];
                    end
                    filt_d[gi] <= filt[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states, error on unmapped offset
    assign setup   = psel && !penable;
    assign wr_ctrl = psel && penable && pwrite && (paddr == sar_pkg::OFS_CTRL);

    // Ready held high after reset; read data prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                pslverr <= 1'b0;
                prdata  <= 32'h0;
                unique case (paddr)
                    sar_pkg::OFS_CTRL:   prdata <= {23'h0, ctrl};
                    sar_pkg::OFS_STATUS: prdata <= {29'h0, status};
                    sar_pkg::OFS_RESULT: prdata <= {16'h0, result};
                    default:             pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Control register; soft reset bit clears itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= sar_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= pwdata[8:0];
        end else begin
            ctrl.soft_reset <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    assign conv_done = (state == sar_pkg::ST_CONV) && (cnt == 8'(sar_pkg::CONV_CYC - 1));

    // Acquire, wait for strobe, convert, or rest in power down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state  <= sar_pkg::ST_ACQ;
            cnt    <= 8'h0;
            busy   <= 1'b0;
            result <= 16'h0;
        end else if (ctrl.soft_reset) begin
            state <= sar_pkg::ST_ACQ;
            cnt   <= 8'h0;
            busy  <= 1'b0;
        end else begin
            unique case (state)
                sar_pkg::ST_ACQ: begin
                    cnt <= cnt + 8'h1;
                    if (cnt == 8'(sar_pkg::ACQ_CYC - 1)) begin
                        cnt <= 8'h0;
                        if (ctrl.power_down) begin
                            state <= sar_pkg::ST_PD;
                        end else if (!cnv_f) begin
                            state <= sar_pkg::ST_CONV;
                            busy  <= 1'b1;
                        end else begin
                            state <= sar_pkg::ST_WAIT;
                        end
                    end
                end
                sar_pkg::ST_WAIT: begin
                    if (ctrl.power_down) begin
                        state <= sar_pkg::ST_PD;
                    end else if (!cnv_f && filt_d[0]) begin
                        state <= sar_pkg::ST_CONV;
                        busy  <= 1'b1;
                    end
                end
                sar_pkg::ST_CONV: begin
                    cnt <= cnt + 8'h1;
                    if (conv_done) begin
                        cnt    <= 8'h0;
                        busy   <= 1'b0;
                        result <= ctrl.code_format_select ? sample_data
                                  : {~sample_data[15], sample_data[14:0]};
                        state  <= ctrl.power_down ? sar_pkg::ST_PD : sar_pkg::ST_ACQ;
                    end
                end
                sar_pkg::ST_PD: begin
                    if (!ctrl.power_down) begin
                        state <= sar_pkg::ST_ACQ;
                    end
                end
            endcase
        end
    end

    // Power pins follow control bits and power-down state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_enable    <= 1'b1;
            buffer_enable <= 1'b1;
            power_reduced <= 1'b0;
        end else begin
            ref_enable    <= !ctrl.ref_off;
            buffer_enable <= !ctrl.buffer_off;
            power_reduced <= (state == sar_pkg::ST_PD);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial read control
    assign ext_edge  = !sel_f && (sclk_f != filt_d[3])
                       && (sclk_f == !ctrl.shift_clock_invert);
    assign half_tick = (div == 8'(sar_pkg::SCLK_HALF_CYC - 1));
    assign start     = ctrl.serial_select && read_act && !shifting && !read_done
                       && (ctrl.external_clock_select || !busy || chain_f);
    assign late_evt  = conv_done && shifting && ctrl.external_clock_select
                       && (bit_cnt < 5'd16);

    // Internal clock divider runs only during an internal read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 8'h0;
        end else if (!shifting || ctrl.external_clock_select || half_tick) begin
            div <= 8'h0;
        end else begin
            div <= div + 8'h1;
        end
    end

    // Shift register, frame marker and internal shift clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg             <= 16'h0;
            serial_result_out <= 1'b0;
            shifting          <= 1'b0;
            read_done         <= 1'b0;
            bit_cnt           <= 5'd0;
            frame_marker      <= 1'b0;
            shift_clock_out   <= 1'b1;
        end else if (ctrl.soft_reset || late_evt) begin
            shifting     <= 1'b0;
            read_done    <= 1'b1;
            frame_marker <= ctrl.frame_marker_invert;
        end else if (!shifting) begin
            frame_marker    <= ctrl.frame_marker_invert;
            shift_clock_out <= !ctrl.shift_clock_invert;
            if (!read_act) begin
                read_done <= 1'b0;
            end
            if (start) begin
                shifting          <= 1'b1;
                shreg             <= result;
                serial_result_out <= result[15];
                bit_cnt           <= 5'd0;
                if (!ctrl.external_clock_select) begin
                    frame_marker <= !ctrl.frame_marker_invert;
                end
            end
        end else if (ctrl.external_clock_select) begin
            if (sel_f) begin
                shifting  <= 1'b0;
                read_done <= 1'b1;
            end else if (ext_edge) begin
                shreg             <= {shreg[14:0], chain_f};
                serial_result_out <= shreg[14];
                if (bit_cnt < 5'd16) begin
                    bit_cnt <= bit_cnt + 5'd1;
                end
            end
        end else if (half_tick) begin
            shift_clock_out <= !shift_clock_out;
            if (shift_clock_out == !ctrl.shift_clock_invert) begin
                bit_cnt <= bit_cnt + 5'd1;
            end else if (bit_cnt == 5'd16) begin
                shifting     <= 1'b0;
                read_done    <= 1'b1;
                frame_marker <= ctrl.frame_marker_invert;
            end else begin
                shreg             <= {shreg[14:0], 1'b0};
                serial_result_out <= shreg[14];
            end
        end
    end

    // Late read flag stretched so a slow host can see it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            late_cnt       <= 8'h0;
            late_read_flag <= 1'b0;
        end else begin
            if (late_evt) begin
                late_cnt <= 8'(sar_pkg::LATE_PULSE_CYC);
            end else if (late_cnt != 8'h0) begin
                late_cnt <= late_cnt - 8'h1;
            end
            late_read_flag <= (late_cnt != 8'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output bus mapping
    always_comb begin
        next_data = result;
        next_oe   = {4'hf, {12{read_act}}};
        if (ctrl.serial_select) begin
            next_data = {result[15:12], late_read_flag, frame_marker,
                         shift_clock_out, serial_result_out, 8'h00};
            next_oe   = {4'hf, read_act && ctrl.external_clock_select,
                         read_act && !ctrl.external_clock_select,
                         read_act && !ctrl.external_clock_select, read_act, 8'h00};
        end
    end

    // Registered bus pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_out       <= 16'h0;
            data_oe        <= 16'hf000;
            shift_clock_oe <= 1'b0;
        end else begin
            data_out       <= next_data;
            data_oe        <= next_oe;
            shift_clock_oe <= ctrl.serial_select && !ctrl.external_clock_select && read_act;
        end
    end
endmodule
`default_nettype wire

/* File: test/sar_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_chk (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        pslverr,
    input  wire logic [15:0] data_oe,
    input  wire logic        select_n,
    input  wire logic        late_read_flag,
    input  wire logic        busy,
    input  wire logic        frame_marker,
    input  wire logic        ref_enable,
    input  wire logic        buffer_enable,
    input  wire logic        power_reduced
);
    logic [7:0] run;  // Busy cycles so far
    logic       wr;   // Control write accepted
    assign wr = psel && penable && pwrite && (paddr == 8'h00);
    ////////////////////////////////////////////////////////////////
    // Length of the current busy stretch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 8'h00;
        end else begin
            run <= busy ? run + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    oe_high_a: assert property (data_oe[15:12] == 4'hf) else $error("upper bits undriven");
    oe_gate_a: assert property (select_n [*8] |-> data_oe[10:0] == 11'h000) else $error("bus driven unselected");
    busy_len_a: assert property (busy |-> run < 8'(sar_pkg::CONV_CYC)) else $error("busy too long");
    late_pulse_a: assert property ($rose(late_read_flag) |-> late_read_flag [*8] ##1 !late_read_flag)
        else $error("late pulse width");
    idle_out_a: assert property ($rose(presetn) |-> !busy && !late_read_flag && !frame_marker)
        else $error("outputs not idle");
    ref_ctl_a: assert property (wr |-> ##2 (ref_enable == !$past(pwdata[6], 2))) else $error("reference control");
    buf_ctl_a: assert property (wr |-> ##2 (buffer_enable == !$past(pwdata[7], 2))) else $error("buffer control");
    pd_block_a: assert property ($rose(busy) |-> !$past(power_reduced)) else $error("start while powered down");
    unmapped_err_a: assert property (psel && penable && paddr > 8'h08 |-> pslverr) else $error("unmapped no error");
endmodule
bind sar_readout sar_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
    .data_oe, .select_n, .late_read_flag, .busy, .frame_marker, .ref_enable, .buffer_enable, .power_reduced);
`default_nettype wire

/* File: test/sar_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_host (
    input  wire logic pclk,
    input  wire logic shift_clock_out,
    input  wire logic serial_result_out,
    input  wire logic frame_marker,
    output logic      select_n,
    output logic      read_strobe_n,
    output logic      shift_clock_in
);
    // Idle host, clock stands still
    initial begin
        select_n = 1'b1;
        read_strobe_n = 1'b1;
        shift_clock_in = 1'b0;
    end
    // Select and read asserted together
    task automatic open_read();
        @(posedge pclk);
        select_n <= 1'b0;
        read_strobe_n <= 1'b0;
    endtask
    task automatic close_read();
        @(posedge pclk);
        select_n <= 1'b1;
        read_strobe_n <= 1'b1;
    endtask
    // Takes bits on the device clock's sampling edge while frame active
    task automatic int_read(input logic act, input logic inv, output logic [15:0] w, output logic ok);
        int n;
        logic p;
        n = 0;
        p = ~inv;
        w = 16'h0000;
        open_read();
        for (int t = 0; t < 400 && n < 16; t++) begin
            @(posedge pclk);
            if (frame_marker === act && p === ~inv && shift_clock_out === inv) begin
                w = {w[14:0], serial_result_out};
                n++;
            end
            p = shift_clock_out;
        end
        ok = (n == 16);
        close_read();
    endtask
    // Sample before each rising edge, 400 ns periods
    task automatic ext_bits(input int n, output logic [31:0] w);
        w = 32'h0;
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            w = {w[30:0], serial_result_out};
            shift_clock_in <= 1'b1;
            repeat (4) @(posedge pclk);
            shift_clock_in <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask
endmodule
`default_nettype wire

/* File: test/sar_readout_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_readout_bench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r, w32;
    logic        pready, pslverr, e, ok, convert_strobe_n = 1'b1, chain = 1'b0;
    logic [15:0] sample_data = 16'h0000, data_out, data_oe, w16;
    logic select_n, read_strobe_n, shift_clock_in, shift_clock_out, serial_result_out;
    logic frame_marker, late_read_flag, busy, ref_enable, buffer_enable, power_reduced, sck_oe;
    int failures = 0, check_count = 0, t;
    always #25 pclk = ~pclk;
    sar_readout DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .convert_strobe_n, .select_n, .read_strobe_n, .shift_clock_in, .readmode_or_chain_in(chain),
        .sample_data, .data_out, .data_oe, .shift_clock_out, .shift_clock_oe(sck_oe), .serial_result_out,
        .frame_marker, .late_read_flag, .busy, .ref_enable, .buffer_enable, .power_reduced);
    sar_host host (.pclk, .shift_clock_out, .serial_result_out, .frame_marker, .select_n, .read_strobe_n,
        .shift_clock_in);
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic c, input string m);
        check_count++;
        if (c !== 1'b1) begin
            failures++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        for (t = 0; busy !== lvl && t < lim; t++) @(posedge pclk);
        chk(busy === lvl, "busy wait");
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs();
        chk(busy === 1'b0 && late_read_flag === 1'b0 && frame_marker === 1'b0, "idle");
        chk(data_oe === 16'hf000 && ref_enable === 1'b1 && buffer_enable === 1'b1, "reset");
        apb(1'b1, 8'h00, 32'hc0);
        apb(1'b0, 8'h00, 32'h0);
        chk(r === 32'hc0 && e === 1'b0, "ctrl readback");
        chk(ref_enable === 1'b0 && buffer_enable === 1'b0, "power off");
        apb(1'b0, 8'h0c, 32'h0);
        chk(e === 1'b1, "unmapped");
        apb(1'b1, 8'h00, 32'h0);
        $display("regs done");
    endtask
    // Edge start, then restart after acquisition with strobe held low
    task automatic t_conv();
        @(posedge pclk);
        {sample_data, convert_strobe_n} <= {16'h1234, 1'b0};
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 60);
        wait_busy(1'b1, 16);
        t = 1;
        @(posedge pclk);
        convert_strobe_n <= 1'b1;
        while (busy === 1'b1 && t < 100) begin
            t++;
            @(posedge pclk);
        end
        chk(t == sar_pkg::CONV_CYC, "busy length");
        apb(1'b0, 8'h08, 32'h0);
        chk(r[15:0] === 16'h9234, "result coding");
        repeat (40) @(posedge pclk);
        chk(busy === 1'b0, "started without edge");
        host.open_read();
        repeat (6) @(posedge pclk);
        chk(data_oe === 16'hffff && data_out === 16'h9234 && sck_oe === 1'b0, "parallel read");
        host.close_read();
        repeat (6) @(posedge pclk);
        chk(data_oe === 16'hf000, "parallel release");
        $display("conv done");
    endtask
    task automatic t_serial();
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 8'h00, 32'h01 | ((i & 1) << 2) | ((i >> 1) << 3));
            host.int_read(i != 1, i == 2, w16, ok);
            chk(ok && w16 === 16'h9234, "internal serial");
            chk(sck_oe === 1'b1 && data_oe[11:8] === 4'b0111, "internal drivers");
            repeat (4) @(posedge pclk);
            chk(frame_marker === (i == 1), "frame idle");
        end
        apb(1'b1, 8'h00, 32'h03);
        chain <= 1'b1;
        host.open_read();
        repeat (6) @(posedge pclk);
        host.ext_bits(20, w32);
        host.close_read();
        chk(sck_oe === 1'b0 && data_oe[11:8] === 4'b1001, "external drivers");
        chk(w32[19:0] === {16'h9234, 4'hf}, "external chain");
        $display("serial done");
    endtask
    // Read still running when next result lands
    task automatic t_late();
        @(posedge pclk);
        convert_strobe_n <= 1'b0;
        wait_busy(1'b1, 20);
        convert_strobe_n <= 1'b1;
        host.open_read();
        repeat (6) @(posedge pclk);
        host.ext_bits(2, w32);
        for (t = 0; late_read_flag !== 1'b1 && t < 40; t++) @(posedge pclk);
        chk(late_read_flag === 1'b1, "late flag");
        host.close_read();
        $display("late done");
    endtask
    task automatic t_pd();
        apb(1'b1, 8'h00, 32'h10);
        convert_strobe_n <= 1'b0;
        wait_busy(1'b1, 20);
        apb(1'b1, 8'h00, 32'h30);
        chk(busy === 1'b1, "conversion cut");
        wait_busy(1'b0, 40);
        repeat (40) @(posedge pclk);
        chk(busy === 1'b0 && power_reduced === 1'b1, "power down");
        apb(1'b0, 8'h08, 32'h0);
        chk(r[15:0] === 16'h1234, "straight coding");
        apb(1'b0, 8'h04, 32'h0);
        chk(r[2:0] === 3'b010, "status powered down");
        apb(1'b1, 8'h00, 32'h0);
        wait_busy(1'b1, 40);
        apb(1'b1, 8'h00, 32'h100);
        convert_strobe_n <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(busy === 1'b0, "abort");
        $display("power done");
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        t_regs();
        t_conv();
        t_serial();
        t_late();
        t_pd();
        summarize();
    end
    initial begin
        #400000;
        failures++;
        summarize();
    end
endmodule
`default_nettype wire
